// ### verilog/watchdog_unit.v
// Decided for this implementation: the APB interface to the registers.
`include "watchdog_unit_defines.vh"

module watchdog_unit #(
  parameter [11:0] VERSION_NUMBER = 12'h123, // Arbitrary value
  parameter [3:0]  VARIANT_NUMBER = 4'h0     // Arbitrary value
) (
  // Bus clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  // Counter clock sources, asynchronous pins
  input  wire        system_rc_oscillator,
  input  wire        crystal_32khz,
  // Toward the reset controller
  output reg         watchdog_reset_request,
  output reg         flash_calibration_redo
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Interval length of two to the (sel + 1)
  function [33:0] interval;
    input [4:0] sel;
    begin
      interval = 34'h000000001 << (sel + 6'h01);
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg  [23:0] control;        // Stored control bits
  reg  [23:0] staged_control; // Data of first keyed control write
  reg         control_armed;
  reg         clear_armed;
  reg         staged_clear;
  reg         en_active;      // Enable as seen by the counter
  reg         control_pend;   // Control change awaiting counter tick
  reg         clear_pend;     // Clear awaiting counter tick
  reg         cleared;
  reg  [33:0] counter;
  reg  [2:0]  rc_sync;
  reg  [2:0]  xt_sync;
  reg         rc_level;
  reg         xt_level;
  reg         rc_prev;
  reg         xt_prev;

  wire [9:0]  offset      = paddr[9:0];
  wire        bus_setup   = psel & ~penable;
  wire        bus_write   = psel & penable & pwrite;
  wire [7:0]  wkey        = pwdata[`KEY_HI:`KEY_LO];
  wire        mode        = control[`BIT_MODE];
  wire [4:0]  psel_field  = control[`PSEL_HI:`PSEL_LO];
  wire [4:0]  tban_field  = control[`TBAN_HI:`TBAN_LO];
  wire [33:0] ban_len     = interval(tban_field);
  wire [33:0] total_len;
  wire        in_ban;
  wire        tick;
  wire        mapped;
  reg  [23:0] next_control;

  assign pready = 1'b1; // Every access completes in its first access cycle

  // Window mode adds the ban interval ahead of the timeout
  assign total_len = mode ? ban_len + interval(psel_field)
                          : interval(psel_field);
  assign in_ban    = mode & (counter < ban_len);

  assign mapped = (offset == `OFS_CONTROL) | (offset == `OFS_CLEAR) |
                  (offset == `OFS_STATUS) | (offset == `OFS_REVISION);

  // ----------------------------------------------------------------
  // Counter clock sources
  // ----------------------------------------------------------------
  // Three stages per pin; level only follows once stages two and three
  // agree, so a metastable sample never reaches the counter.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_sync  <= 3'h0;
      xt_sync  <= 3'h0;
      rc_level <= 1'b0;
      xt_level <= 1'b0;
      rc_prev  <= 1'b0;
      xt_prev  <= 1'b0;
    end else begin
      rc_sync <= {rc_sync[1:0], system_rc_oscillator};
      xt_sync <= {xt_sync[1:0], crystal_32khz};
      if (rc_sync[1] == rc_sync[2]) begin
        rc_level <= rc_sync[2];
      end
      if (xt_sync[1] == xt_sync[2]) begin
        xt_level <= xt_sync[2];
      end
      rc_prev <= rc_level;
      xt_prev <= xt_level;
    end
  end

  // Rising edge of the selected source, gated by clock enable.
  // Sources must be well below pclk/4 for edges to be seen.
  assign tick = control[`BIT_CEN] &
                (control[`BIT_COUNTER_CLOCK_SELECT] ? (xt_level & ~xt_prev)
                                     : (rc_level & ~rc_prev));

  // ----------------------------------------------------------------
  // Candidate control value of a keyed write
  // ----------------------------------------------------------------
  always @* begin
    next_control = staged_control & `CONTROL_WMASK;
    if (en_active) begin
      next_control[`BIT_MODE] = control[`BIT_MODE];
    end
    // Lock is sticky: software can set it, never clear it
    next_control[`BIT_LOCK] = next_control[`BIT_LOCK] |
                              control[`BIT_LOCK];
  end

  // ----------------------------------------------------------------
  // Registers, handshake and counter
  // ----------------------------------------------------------------
  // One process owns the control, handshake and counter bits, so bus writes and counter events
  // on the same edge resolve in a fixed order.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control                <= `CONTROL_RESET;
      staged_control         <= 24'h000000;
      control_armed          <= 1'b0;
      clear_armed            <= 1'b0;
      staged_clear           <= 1'b0;
      en_active              <= 1'b0;
      control_pend           <= 1'b0;
      clear_pend             <= 1'b0;
      cleared                <= 1'b1;
      counter                <= 34'h000000000;
      watchdog_reset_request <= 1'b0;
      flash_calibration_redo <= 1'b0;
    end else begin
      watchdog_reset_request <= 1'b0;
      flash_calibration_redo <= 1'b0;

      // Counter side: applies pending requests on its own tick
      if (tick) begin
        if (control_pend) begin
          en_active    <= control[`BIT_EN];
          counter      <= 34'h000000000;
          control_pend <= 1'b0;
        end else if (clear_pend) begin
          if (en_active & in_ban) begin
            watchdog_reset_request <= 1'b1;
            flash_calibration_redo <= ~control[`BIT_CALDONE];
          end
          counter    <= 34'h000000000;
          clear_pend <= 1'b0;
          cleared    <= 1'b1;
        end else if (en_active) begin
          if (counter >= total_len - 34'h000000001) begin
            watchdog_reset_request <= 1'b1;
            flash_calibration_redo <= ~control[`BIT_CALDONE];
            counter                <= 34'h000000000;
            if (control[`BIT_DAR]) begin
              en_active          <= 1'b0;
              control[`BIT_EN]   <= 1'b0;
            end
          end else begin
            counter <= counter + 34'h000000001;
          end
        end
      end

      // Bus side: keyed writes, the second must repeat the first
      if (bus_write && offset == `OFS_CONTROL) begin
        if (wkey == `KEY_FIRST) begin
          staged_control <= pwdata[23:0];
          control_armed  <= 1'b1;
        end else begin
          control_armed <= 1'b0;
          if (wkey == `KEY_SECOND && control_armed &&
              pwdata[23:0] == staged_control &&
              !control[`BIT_LOCK]) begin
            if (next_control != control) begin
              control      <= next_control;
              control_pend <= 1'b1;
            end
          end
        end
      end
      if (bus_write && offset == `OFS_CLEAR) begin
        if (wkey == `KEY_FIRST) begin
          staged_clear <= pwdata[`BIT_CLRREQ];
          clear_armed  <= 1'b1;
        end else begin
          clear_armed <= 1'b0;
          if (wkey == `KEY_SECOND && clear_armed &&
              staged_clear && pwdata[`BIT_CLRREQ] &&
              cleared && !clear_pend) begin
            clear_pend <= 1'b1;
            cleared    <= 1'b0;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data and error response
  // ----------------------------------------------------------------
  // Captured in the setup cycle so it stands through the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (bus_setup) begin
      pslverr <= ~mapped;
      prdata  <= 32'h00000000;
      if (!pwrite) begin
        case (offset)
          `OFS_CONTROL:
            prdata <= {8'h00, control[23:1], en_active};
          `OFS_STATUS:
            prdata <= {30'h00000000, cleared, ~in_ban};
          `OFS_REVISION:
            prdata <= {12'h000, VARIANT_NUMBER,
                       4'h0, VERSION_NUMBER};
          default:
            prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Registers sit entirely on pclk; only the counter tick comes
  // from the sampled oscillator pins.

endmodule // watchdog_unit

// ### verilog/watchdog_unit_defines.vh
// Overview of operation
// - Control and clear need key 55 then AA
// - Control key field always reads zero
// - Clear inside ban interval forces reset, clears
// - Source select: 0 RC oscillator, 1 crystal
// - Clock enable gates counter, resets to one
// - Timeout prescale picks counter end bit
// - Calibration done set at reset, steers recalibration
// - Lock bit blocks control writes until reset
// - Mode: basic timeout, or ban plus timeout
// - Mode bit frozen while watchdog enabled
// - Disable-after-reset turns watchdog off at timeout
// - Enable reads back only once applied
// - Clear bit one clears counter, zero nothing
// - Cleared flag drops on clear, sets when done
// - In-window flag zero in ban, one after
// - Read-only version register at 0x3FC
// - Registers run on the bus clock
// - Basic timeout is two to prescale plus one
// - Ban interval is two to ban plus one
// - Clear while not cleared is ignored
// - Accepted control change clears counter, no reset
`ifndef WATCHDOG_UNIT_DEFINES_VH
`define WATCHDOG_UNIT_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_CONTROL   10'h000
`define OFS_CLEAR     10'h004
`define OFS_STATUS    10'h008
`define OFS_REVISION  10'h3FC

// ----------------------------------------------------------------
// Keys and field positions
// ----------------------------------------------------------------
`define KEY_FIRST     8'h55
`define KEY_SECOND    8'hAA
`define KEY_HI        31
`define KEY_LO        24
`define BIT_EN        0
`define BIT_DAR       1
`define BIT_MODE      2
`define BIT_LOCK      3
`define BIT_CALDONE   7
`define PSEL_HI       12
`define PSEL_LO       8
`define BIT_CEN       16
`define BIT_COUNTER_CLOCK_SELECT     17
`define TBAN_HI       22
`define TBAN_LO       18
`define BIT_CLRREQ    0
`define BIT_WINDOW    0
`define BIT_CLEARED   1

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define CONTROL_RESET 24'h010080
`define CONTROL_WMASK 24'h7F1F8F
`define STATUS_RESET  2'h3

`endif

// ### verif/watchdog_unit_properties.sv
module watchdog_unit_properties #(
  parameter [11:0] VERSION_NUMBER = 12'h123,
  parameter [3:0]  VARIANT_NUMBER = 4'h0
) (
  // Bus side
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  // Reset controller side
  input logic        watchdog_reset_request,
  input logic        flash_calibration_redo
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Decode
  // ----
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Only bits 9:0 are decoded, so aliases map too
  wire       ac = psel && penable;
  wire       rd = ac && !pwrite;
  wire [9:0] a  = paddr[9:0];
  wire       ok = a == 10'h000 || a == 10'h004 || a == 10'h008
                  || a == 10'h3FC;
  // ----
  // Properties
  // ----
  property p_key; rd && a == 10'h000 |-> (prdata & 32'hFF80E070) == 0;
  endproperty
  a_key: assert property (p_key) else $error("key bits read");
  property p_rev; rd && a == 10'h3FC |->
    prdata == {12'h000, VARIANT_NUMBER, 4'h0, VERSION_NUMBER}; endproperty
  a_rev: assert property (p_rev) else $error("bad revision");
  property p_sts; rd && a == 10'h008 |-> prdata[31:2] == 30'h0; endproperty
  a_sts: assert property (p_sts) else $error("status spare set");
  property p_err; ac && !ok |-> pslverr && (pwrite || prdata == 0);
  endproperty
  a_err: assert property (p_err) else $error("unmapped ok");
  property p_ok; ac && ok |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("mapped error");
  property p_rdy; ac |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("wait state");
  property p_pls; watchdog_reset_request |=> !watchdog_reset_request;
  endproperty
  a_pls: assert property (p_pls) else $error("reset not pulse");
  property p_cal; flash_calibration_redo |-> watchdog_reset_request;
  endproperty
  a_cal: assert property (p_cal) else $error("lone redo");
endmodule // watchdog_unit_properties

bind watchdog_unit watchdog_unit_properties #(
  .VERSION_NUMBER(VERSION_NUMBER),
  .VARIANT_NUMBER(VARIANT_NUMBER)
) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .watchdog_reset_request(watchdog_reset_request),
  .flash_calibration_redo(flash_calibration_redo)
);

// ### verif/watchdog_unit_tb.sv
module watchdog_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Signals
  // ----
  localparam logic [11:0] ctl = 12'h000, clear = 12'h004;
  localparam logic [11:0] stat = 12'h008, rev = 12'h3FC;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic        pready, pslverr, wrq, redo;
  logic        rc = 0, xt = 0, run_rc = 1, run_xt = 0;
  int          bad_count = 0, checks = 0, rsts = 0, redos = 0, ph = 0;
  watchdog_unit dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .system_rc_oscillator(rc),
    .crystal_32khz(xt), .watchdog_reset_request(wrq),
    .flash_calibration_redo(redo));
  // 125 MHz bus clock
  initial forever #4 pclk = ~pclk;
  // Slow sources; rc ticks every 8 pclk, crystal every 10
  always @(posedge pclk) begin
    ph <= ph + 1;
    if (ph % 4 == 3) rc <= rc ^ run_rc;
    if (ph % 5 == 4) xt <= xt ^ run_xt;
    if (wrq === 1'b1) rsts <= rsts + 1;
    if (redo === 1'b1) redos <= redos + 1;
  end
  // ----
  // Tasks
  // ----
  task chk(input [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits on pready rather than assuming zero waits
  task xfer(input w, input [11:0] a, input [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1 && n++ < 50) @(posedge pclk);
    if (pready !== 1'b1) bad_count++;
    q = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task kw(input [11:0] a, input [23:0] d);
    xfer(1, a, {8'h55, d});
    xfer(1, a, {8'hAA, d});
  endtask
  task rchk(input [11:0] a, input [31:0] e);
    xfer(0, a, 32'h0);
    chk(q, e);
  endtask
  // Read-back lags behind the slow counter side, so re-read a while
  task poll(input [11:0] a, input [31:0] m, e);
    int n;
    n = 0;
    do xfer(0, a, 32'h0); while ((q & m) !== e && ++n < 40);
    chk(q & m, e);
  endtask
  task tk(input int n);
    repeat (n * 8) @(posedge pclk);
  endtask
  task results;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard, more than ten times the expected run
  initial begin
    #200000;
    bad_count++;
    results;
  end
  // ----
  // Sequence
  // ----
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    rchk(ctl, 32'h00010080);
    rchk(stat, 32'h00000003);
    rchk(rev, 32'h00000123);
    rchk(12'h010, 32'h0);
    run_rc <= 0;
    tk(2);
    xfer(1, ctl, 32'h55010381);
    xfer(1, ctl, 32'h00010381);
    rchk(ctl, 32'h00010080);
    kw(ctl, 24'h010381);
    rchk(ctl, 32'h00010380);
    run_rc <= 1;
    poll(ctl, '1, 32'h00010381);
    repeat (4) begin
      kw(clear, 24'h000001);
      tk(6);
    end
    chk(rsts, 32'h0);
    kw(clear, 24'h000000);
    rchk(stat, 32'h00000003);
    run_rc <= 0;
    tk(2);
    kw(clear, 24'h000001);
    rchk(stat, 32'h00000001);
    run_rc <= 1;
    tk(3);
    rchk(stat, 32'h00000003);
    tk(10);
    kw(ctl, 24'h010305);
    tk(10);
    chk(rsts, 32'h0);
    rchk(ctl, 32'h00010301);
    kw(clear, 24'h000001);
    tk(12);
    chk(rsts, 32'h0);
    tk(8);
    chk(rsts, 32'h1);
    chk(redos, 32'h1);
    poll(ctl, 32'h1, 32'h1);
    kw(ctl, 24'h010383);
    tk(20);
    poll(ctl, 32'h1, 32'h0);
    chk(rsts, 32'h2);
    chk(redos, 32'h1);
    run_rc <= 0;
    run_xt <= 1;
    kw(ctl, 24'h030381);
    poll(ctl, '1, 32'h00030381);
    kw(ctl, 24'h030380);
    poll(ctl, '1, 32'h00030380);
    run_rc <= 1;
    kw(ctl, 24'h090385);
    poll(ctl, '1, 32'h00090385);
    rchk(stat, 32'h00000002);
    tk(9);
    rchk(stat, 32'h00000003);
    kw(clear, 24'h000001);
    tk(3);
    chk(rsts, 32'h2);
    kw(clear, 24'h000001);
    tk(3);
    chk(rsts, 32'h3);
    tk(18);
    chk(rsts, 32'h3);
    tk(10);
    chk(rsts, 32'h4);
    kw(ctl, 24'h09038D);
    poll(ctl, '1, 32'h0009038D);
    kw(ctl, 24'h010080);
    tk(4);
    rchk(ctl, 32'h0009038D);
    @(posedge pclk);
    presetn <= 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    rchk(ctl, 32'h00010080);
    results;
  end
endmodule // watchdog_unit_tb
